/* logic/aicg_clamp_chan.sv */
// One channel clamp comparator
`timescale 1ns/1ps
module aicg_clamp_chan
  import aicg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [AICG_SAMPLE_W-1:0] sample,
  input wire aicg_sig_t sig_type,
  input wire logic clamp_en,
  output aicg_clamp_t clamp_r
);
  typedef struct packed {
    aicg_clamp_t clamp;
  } aicg_cc_state_t;
  aicg_cc_state_t st_r, st_nxt;
  logic [AICG_SAMPLE_W-1:0] target;

  always_comb begin
    unique case (sig_type)
      AICG_SIG_LUMA: target = AICG_CLAMP_LUMA;
      AICG_SIG_CHROMA: target = AICG_CLAMP_CHROMA;
      AICG_SIG_COMP_Y: target = AICG_CLAMP_COMP_Y;
      AICG_SIG_COMP_DIFF: target = AICG_CLAMP_COMP_DIFF;
      AICG_SIG_RGB: target = AICG_CLAMP_RGB;
      default: target = AICG_CLAMP_LUMA;
    endcase
  end

  // Next decision; idle outside the window so the capacitor simply holds
  always_comb begin
    st_nxt = '0;
    if (clamp_en) begin
      st_nxt.clamp.up = sample < target;
      st_nxt.clamp.down = sample > target;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign clamp_r = st_r.clamp;
endmodule

/* logic/aicg_pkg.sv */
// Package for the analog input clamp and gain control block
package aicg_pkg;
  localparam int AICG_CHANNELS = 4;
  localparam int AICG_SAMPLE_W = 9;
  localparam int AICG_GAIN_W = 9;
  // Signal type selection per channel
  typedef enum logic [2:0] {
    AICG_SIG_LUMA,
    AICG_SIG_CHROMA,
    AICG_SIG_COMP_Y,
    AICG_SIG_COMP_DIFF,
    AICG_SIG_RGB
  } aicg_sig_t;
  // Clamp target codes
  localparam logic [8:0] AICG_CLAMP_LUMA = 9'h078;
  localparam logic [8:0] AICG_CLAMP_CHROMA = 9'h100;
  localparam logic [8:0] AICG_CLAMP_COMP_Y = 9'h020;
  localparam logic [8:0] AICG_CLAMP_COMP_DIFF = 9'h100;
  localparam logic [8:0] AICG_CLAMP_RGB = 9'h020;
  // Gain loop and filter figures
  localparam logic [8:0] AICG_SYNC_TARGET = 9'h010;
  localparam logic [8:0] AICG_WHITE_LIMIT = 9'h1f8;
  localparam logic [8:0] AICG_GAIN_RESET = 9'h100;
  localparam logic [7:0] AICG_FILT_RESET = 8'h00;
  // Clamp decision toward the analog side
  typedef struct packed {
    logic up;
    logic down;
  } aicg_clamp_t;
endpackage

/* logic/aicg_top.sv */
// Clamp and gain control loops for four video converter channels
// Behaviour
// - Gain and clamp adjustments hold still through vertical blanking.
// - Clamp targets: luma 120, chroma 256, comp Y 32, diff 256, RGB 32.
// - Per channel comparator yields clamp up or down against its target.
// - Clamp corrections only while the horizontal clamp pulse is high.
// - Static gains per amplifier, or one chosen amplifier under automatic gain.
// - Automatic gain fits luma or composite amplitude to converter range.
// - Component channels never use automatic gain, only programmed gain.
// - Automatic gain latches the sync level during sync bottom and updates only at line start.
// - White peak near converter top lowers the automatic gain.
// - Filter tuning follows the measured line-locked sample clock rate.
// - Four 9-bit sample streams pass on to the decimation filter.
`timescale 1ns/1ps
module aicg_top
  import aicg_pkg::*;
#(
  parameter int CHANNELS = AICG_CHANNELS,
  parameter int FILT_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [CHANNELS*AICG_SAMPLE_W-1:0] adc_samples,
  input wire logic [CHANNELS*3-1:0] sig_types,
  input wire logic [CHANNELS*AICG_GAIN_W-1:0] static_gains,
  input wire logic agc_enable,
  input wire logic [1:0] agc_channel,
  input wire logic horizontal_clamp_pulse,
  input wire logic sync_bottom,
  input wire logic vertical_blank,
  input wire logic line_start,
  input wire logic [FILT_W-1:0] clocks_per_line,
  output logic [CHANNELS*AICG_SAMPLE_W-1:0] decimation_filter_samples,
  output logic [CHANNELS-1:0] clamp_up,
  output logic [CHANNELS-1:0] clamp_down,
  output logic [CHANNELS*AICG_GAIN_W-1:0] amp_gains,
  output logic [FILT_W-1:0] filter_tune
);
  // State of the block apart from the clamp decisions, registered in one place
  typedef struct packed {
    // Sample word handed on, one cycle late
    logic [CHANNELS*AICG_SAMPLE_W-1:0] df;
    // Gain words on the amplifier pins
    logic [CHANNELS*AICG_GAIN_W-1:0] gains;
    // Shared automatic gain register and its per line evidence
    logic [AICG_GAIN_W-1:0] agc_gain;
    logic meas_valid;
    logic meas_above;
    logic peak_seen;
    // Filter tuning word
    logic [FILT_W-1:0] filt;
  } aicg_state_t;
  aicg_state_t st_r, st_nxt;

  // Width of one signal type code as packed into sig_types
  localparam int SIG_W = $bits(aicg_sig_t);

  // State after reset: gains start mid scale, all evidence flags clear
  localparam aicg_state_t ST_RESET = '{
    df: '0,
    gains: {CHANNELS{AICG_GAIN_RESET}},
    agc_gain: AICG_GAIN_RESET,
    meas_valid: 1'b0,
    meas_above: 1'b0,
    peak_seen: 1'b0,
    filt: FILT_W'(AICG_FILT_RESET)
  };

  // Per channel views of the packed input buses
  logic [AICG_SAMPLE_W-1:0] sample_chan [CHANNELS];
  logic [AICG_GAIN_W-1:0] static_gain_chan [CHANNELS];
  aicg_sig_t sig_chan [CHANNELS];
  aicg_clamp_t clamp_chan [CHANNELS];

  // Loop qualifiers, all combinational from this cycle's inputs
  logic loop_live;
  logic clamp_en;
  logic meas_now;
  logic peak_now;
  logic step_now;

  // Automatic gain channel selection and step decision
  logic [AICG_SAMPLE_W-1:0] agc_sample;
  aicg_sig_t agc_type;
  logic agc_allowed;
  logic agc_at_top;
  logic agc_at_floor;
  logic step_up;
  logic step_down;

  // Split the packed buses so every later use indexes by channel
  // Slicing the wide bus at every use would repeat the index arithmetic
  for (genvar i = 0; i < CHANNELS; i++) begin : g_split
    assign sample_chan[i] = adc_samples[i*AICG_SAMPLE_W +: AICG_SAMPLE_W];
    assign static_gain_chan[i] = static_gains[i*AICG_GAIN_W +: AICG_GAIN_W];
    // Codes 5 to 7 fall back to the luma target inside the comparator
    assign sig_chan[i] = aicg_sig_t'(sig_types[i*SIG_W +: SIG_W]);
  end

  // loops live outside blanking
  // Vertical blanking carries no usable porch or sync, so every loop waits
  assign loop_live = !vertical_blank;

  assign clamp_en = horizontal_clamp_pulse && loop_live;

  // Clamp comparators, one per channel
  // Each keeps its own registered decision so the pins come straight from flops
  // Limitation: the correction rate is set by the analog charge pump, not here
  for (genvar i = 0; i < CHANNELS; i++) begin : g_clamp
    aicg_clamp_chan u_clamp (
      .clk_sys(clk_sys),
      .reset(reset),
      .sample(sample_chan[i]),
      .sig_type(sig_chan[i]),
      .clamp_en(clamp_en),
      .clamp_r(clamp_chan[i])
    );
    assign clamp_up[i] = clamp_chan[i].up;
    assign clamp_down[i] = clamp_chan[i].down;
  end

  // Channel that the automatic loop watches
  // Only one channel runs automatically; moving agc_channel carries the
  // shared gain register over to the new channel at once
  assign agc_sample = sample_chan[agc_channel];
  assign agc_type = sig_chan[agc_channel];

  // component sources stay manual
  // Composite shares the luma code, so only that code may run automatically
  assign agc_allowed = agc_enable && (agc_type == AICG_SIG_LUMA);

  assign meas_now = loop_live && sync_bottom;

  assign peak_now = loop_live && (agc_sample >= AICG_WHITE_LIMIT);

  // one step per line
  // Stepping once per line keeps the loop slow against noise on a single sample
  assign step_now = loop_live && line_start;

  // Gain end stops; the loop saturates rather than wrapping
  // A wrap would throw the amplifier from one end of its range to the other
  assign agc_at_top = (st_r.agc_gain == '1);
  assign agc_at_floor = (st_r.agc_gain == '0);

  // sync above target means too little amplitude
  assign step_up = step_now && !st_r.peak_seen && st_r.meas_valid && st_r.meas_above && !agc_at_top;

  // peak wins over sync
  // A line with overshoot steps down unless the gain is at its floor, whatever the sync level said
  assign step_down = step_now && !agc_at_floor && (st_r.peak_seen || (st_r.meas_valid && !st_r.meas_above));

  // Timing of one automatic step: the sync level is latched in one cycle,
  // the gain register moves at the next line start, and the amplifier word
  // follows one cycle later; blanking stalls every stage of that chain
  always_comb begin
    // Every field holds unless a branch below moves it
    st_nxt = st_r;

    st_nxt.df = adc_samples;

    // filter follows line rate
    // The rate figure is only trusted once per line, at its start
    if (line_start) begin
      st_nxt.filt = clocks_per_line;
    end

    // apply the step and start a new line
    // The clear comes first so that an event in the same cycle is kept
    if (step_now) begin
      st_nxt.meas_valid = 1'b0;
      st_nxt.peak_seen = 1'b0;
    end
    if (step_up) begin
      st_nxt.agc_gain = st_r.agc_gain + 1'b1;
    end else if (step_down) begin
      st_nxt.agc_gain = st_r.agc_gain - 1'b1;
    end

    // latch the sync bottom level
    // The last sync sample of a line is the one that counts
    if (meas_now) begin
      st_nxt.meas_valid = 1'b1;
      st_nxt.meas_above = agc_sample > AICG_SYNC_TARGET;
    end

    if (peak_now) begin
      st_nxt.peak_seen = 1'b1;
    end

    // static gains, one automatic; hold in blanking
    if (loop_live) begin
      for (int i = 0; i < CHANNELS; i++) begin
        st_nxt.gains[i*AICG_GAIN_W +: AICG_GAIN_W] = static_gain_chan[i];
      end
      if (agc_allowed) begin
        st_nxt.gains[agc_channel*AICG_GAIN_W +: AICG_GAIN_W] = st_r.agc_gain;
      end
    end
  end

  // State register
  // Synchronous reset; every field takes its reset value on the same edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  // The amplifiers see a new gain one cycle after the loop decides it
  assign decimation_filter_samples = st_r.df;
  assign amp_gains = st_r.gains;
  assign filter_tune = st_r.filt;
endmodule

/* sim/aicg_afe_model.sv */
// Converter model: presents each channel level as its 9-bit sample
`timescale 1ns/1ps
module aicg_afe_model
  import aicg_pkg::*;
(
  input wire logic [35:0] levels,
  output logic [35:0] adc_samples
);
  // Ideal converter; amplifier gain is taken as folded into the levels
  assign adc_samples = levels;
endmodule

/* sim/aicg_properties.sv */
// Checker for the clamp and gain control block
`timescale 1ns/1ps
module aicg_properties
  import aicg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [35:0] adc_samples,
  input wire logic [11:0] sig_types,
  input wire logic [35:0] static_gains,
  input wire logic agc_enable,
  input wire logic [1:0] agc_channel,
  input wire logic horizontal_clamp_pulse,
  input wire logic vertical_blank,
  input wire logic line_start,
  input wire logic [7:0] clocks_per_line,
  input wire logic [35:0] decimation_filter_samples,
  input wire logic [3:0] clamp_up,
  input wire logic [3:0] clamp_down,
  input wire logic [35:0] amp_gains,
  input wire logic [7:0] filter_tune
);
  // Channel 0 clamp window, its target and its automatic gain state
  wire logic en = horizontal_clamp_pulse && !vertical_blank;
  wire logic agc_on = agc_enable && agc_channel == 2'h0 && sig_types[2:0] == 3'h0 && !vertical_blank;
  wire logic [2:0] t0 = sig_types[2:0];
  wire logic [8:0] tgt = (t0 == 3'h1 || t0 == 3'h3) ? 9'h100 : (t0 == 3'h2 || t0 == 3'h4) ? 9'h020 : 9'h078;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  samp_delay_a: assert property (!$past(reset) |-> decimation_filter_samples == $past(adc_samples))
    else $error("sample delay");
  clamp_idle_a: assert property (!$past(reset) && !$past(en) |-> clamp_up == 4'h0 && clamp_down == 4'h0)
    else $error("clamp outside window");
  clamp_level_a: assert property (!$past(reset) && $past(en) |-> clamp_up[0] == ($past(adc_samples[8:0]) < $past(tgt))
    && clamp_down[0] == ($past(adc_samples[8:0]) > $past(tgt))) else $error("clamp decision");
  gain_freeze_a: assert property (!$past(reset) && $past(vertical_blank) |-> $stable(amp_gains))
    else $error("gain moved in blanking");
  static_gain_a: assert property (!$past(reset) && $past(!vertical_blank && !agc_on)
    |-> amp_gains[8:0] == $past(static_gains[8:0])) else $error("static gain");
  filter_follow_a: assert property (!$past(reset) && $past(line_start) |-> filter_tune == $past(clocks_per_line))
    else $error("filter tune");
  agc_hold_a: assert property (!$past(reset) && $past(agc_on) && $past(agc_on, 2) && !$past(line_start, 2)
    |-> $stable(amp_gains[8:0])) else $error("gain moved mid line");
  agc_step_a: assert property (!$past(reset) && $past(agc_on) && $past(agc_on, 2)
    |-> amp_gains[8:0] - $past(amp_gains[8:0]) inside {9'h000, 9'h001, 9'h1ff}) else $error("gain step");
endmodule

/* sim/tb_aicg_top.sv */
// Testbench for the clamp and gain control block
`timescale 1ns/1ps
module tb_aicg_top;
  import aicg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic agc_enable = 1'b0, horizontal_clamp_pulse = 1'b0, sync_bottom = 1'b0, vertical_blank = 1'b0, line_start = 1'b0;
  logic [1:0] agc_channel = 2'h0;
  logic [7:0] clocks_per_line = 8'h00, filter_tune;
  logic [11:0] sig_types = 12'h000;
  logic [35:0] levels = 36'h0, static_gains = {4{9'h100}}, adc_samples, decimation_filter_samples, amp_gains;
  logic [3:0] clamp_up, clamp_down;
  int fails = 0, n_compared = 0;
  // Rows: type, level, expected up, expected down
  logic [13:0] rows [7] = '{{3'h0, 9'h077, 2'h2}, {3'h0, 9'h078, 2'h0}, {3'h0, 9'h079, 2'h1},
    {3'h1, 9'h0ff, 2'h2}, {3'h2, 9'h021, 2'h1}, {3'h3, 9'h100, 2'h0}, {3'h4, 9'h01f, 2'h2}};
  aicg_afe_model afe (.levels(levels), .adc_samples(adc_samples));
  aicg_top dut (.*);
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One line: optional sync bottom cycle, then the line start pulse
  task automatic pulse_line(input logic sb);
    @(posedge clk_sys);
    sync_bottom <= sb;
    @(posedge clk_sys);
    sync_bottom <= 1'b0;
    line_start <= 1'b1;
    clocks_per_line <= clocks_per_line + 8'h2d;
    @(posedge clk_sys);
    line_start <= 1'b0;
    tick(1);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Clock at 40 MHz
  initial forever #12.5 clk_sys = ~clk_sys;
  // Watchdog, far beyond the roughly 80 cycles the run needs
  initial begin
    #20us;
    fails++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk(amp_gains, {4{9'h100}});
    chk(decimation_filter_samples, 36'h0);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      horizontal_clamp_pulse <= 1'b1;
      sig_types <= {4{rows[i][13:11]}};
      levels <= {4{rows[i][10:2]}};
      tick(1);
      chk(clamp_up, {4{rows[i][1]}});
      chk(clamp_down, {4{rows[i][0]}});
      chk(decimation_filter_samples, levels);
    end
    @(posedge clk_sys);
    horizontal_clamp_pulse <= 1'b0;
    tick(1);
    chk(clamp_up, 36'h0);
    chk(clamp_down, 36'h0);
    @(posedge clk_sys);
    horizontal_clamp_pulse <= 1'b1;
    vertical_blank <= 1'b1;
    static_gains <= {4{9'h0aa}};
    tick(1);
    chk(clamp_up, 36'h0);
    chk(clamp_down, 36'h0);
    chk(amp_gains, {4{9'h100}});
    @(posedge clk_sys);
    vertical_blank <= 1'b0;
    sig_types <= {4{3'h2}};
    agc_enable <= 1'b1;
    tick(1);
    chk(amp_gains, {4{9'h0aa}});
    @(posedge clk_sys);
    sig_types <= 12'h000;
    levels <= {4{9'h020}};
    pulse_line(1'b1);
    chk(amp_gains, {{3{9'h0aa}}, 9'h101});
    chk(filter_tune, clocks_per_line);
    @(posedge clk_sys);
    levels <= {4{9'h1f8}};
    @(posedge clk_sys);
    levels <= {4{9'h020}};
    pulse_line(1'b0);
    chk(amp_gains, {{3{9'h0aa}}, 9'h100});
    pulse_line(1'b0);
    chk(amp_gains, {{3{9'h0aa}}, 9'h100});
    @(posedge clk_sys);
    vertical_blank <= 1'b1;
    pulse_line(1'b1);
    chk(amp_gains, {{3{9'h0aa}}, 9'h100});
    @(posedge clk_sys);
    vertical_blank <= 1'b0;
    levels <= {4{9'h008}};
    pulse_line(1'b1);
    chk(amp_gains, {{3{9'h0aa}}, 9'h0ff});
    // Reset in mid-run: outputs and the automatic gain go back to reset values
    @(posedge clk_sys);
    reset <= 1'b1;
    tick(1);
    chk(amp_gains, {4{9'h100}});
    chk(filter_tune, 8'h00);
    chk({clamp_up, clamp_down}, 8'h00);
    chk(decimation_filter_samples, 36'h0);
    @(posedge clk_sys);
    reset <= 1'b0;
    tick(1);
    chk(amp_gains, {{3{9'h0aa}}, 9'h100});
    // Sync bottom in the line start cycle is kept for the next line
    @(posedge clk_sys);
    levels <= {4{9'h020}};
    sync_bottom <= 1'b1;
    line_start <= 1'b1;
    @(posedge clk_sys);
    sync_bottom <= 1'b0;
    line_start <= 1'b0;
    pulse_line(1'b0);
    chk(amp_gains, {{3{9'h0aa}}, 9'h101});
    tally_and_finish();
  end
endmodule
bind aicg_top aicg_properties chk (.*);
